// [core/spims_pkg.sv]
// Shared constants and types of the serial port and its far-end partner.
// Assumes a single core clock and APB-style word addressing.
package spims_pkg;

  // ---------------------------------------------------------------
  // Register map (index times four gives the byte address)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [7:0] CTRL_INDEX = 8'hF8;
  localparam logic [7:0] DATA_INDEX = 8'h7F;
  localparam logic [7:0] GPIO_INDEX = 8'hA0;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] DATA_ADDR = {2'h0, DATA_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] GPIO_ADDR = {2'h0, GPIO_INDEX, 2'h0};

  // ---------------------------------------------------------------
  // Control register fields and reset values
  // ---------------------------------------------------------------
  localparam int BIT_DONE = 7;
  localparam int BIT_WRITE_COLLISION_FLAG = 6;
  localparam int BIT_EN = 5;
  localparam int BIT_MST = 4;
  localparam int BIT_CLOCK_IDLE_LEVEL_BIT = 3;
  localparam int BIT_CLOCK_EDGE_SELECT_BIT = 2;
  localparam int BIT_RATE_HI = 1;
  localparam int BIT_RATE_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h05;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] GPIO_RESET = 8'h00;
  localparam int GPIO_PINS = 4;

  // Bits in one byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } spims_state_t;

  typedef enum logic [3:0] {
    PS_IDLE = 4'b0001,
    PS_SETUP = 4'b0010,
    PS_RUN = 4'b0100,
    PS_HOLD = 4'b1000
  } spims_peer_state_t;

endpackage

// [core/spims_link_if.sv]
// Four-wire serial link between the port and its partner.
// Each pin has output and enable per end; the resolved level is
// pulled high when no end drives, and the port wins a contention.
`timescale 1ns/1ps
interface spims_link_if;
  logic dev_sclk_o, dev_sclk_oe, peer_sclk_o, peer_sclk_oe;
  logic dev_mosi_o, dev_mosi_oe, peer_mosi_o, peer_mosi_oe;
  logic dev_miso_o, dev_miso_oe, peer_miso_o, peer_miso_oe;
  logic dev_ss_n_o, dev_ss_n_oe, peer_ss_n_o, peer_ss_n_oe;
  logic sclk, mosi, miso, ss_n;

  assign sclk = dev_sclk_oe ? dev_sclk_o :
                (peer_sclk_oe ? peer_sclk_o : 1'b1);
  assign mosi = dev_mosi_oe ? dev_mosi_o :
                (peer_mosi_oe ? peer_mosi_o : 1'b1);
  assign miso = dev_miso_oe ? dev_miso_o :
                (peer_miso_oe ? peer_miso_o : 1'b1);
  assign ss_n = dev_ss_n_oe ? dev_ss_n_o :
                (peer_ss_n_oe ? peer_ss_n_o : 1'b1);

  modport dev (
    input sclk, mosi, miso, ss_n,
    output dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe,
    output dev_miso_o, dev_miso_oe, dev_ss_n_o, dev_ss_n_oe
  );
  modport peer (
    input sclk, mosi, miso, ss_n,
    output peer_sclk_o, peer_sclk_oe, peer_mosi_o, peer_mosi_oe,
    output peer_miso_o, peer_miso_oe, peer_ss_n_o, peer_ss_n_oe
  );
endinterface // spims_link_if

// [core/spims_peer.sv]
// Far-end partner: a plain serial master or slave driven by user ports.
// Assumes the link is sampled synchronously to sys_clk.
`timescale 1ns/1ps
module spims_peer #(
  parameter int unsigned HALF_CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  spims_link_if.peer link,
  input wire logic act_master,
  input wire logic clock_idle_level_bit,
  input wire logic clock_edge_select_bit,
  input wire logic sel_n,
  input wire logic [7:0] tx_byte,
  input wire logic start,
  output logic [7:0] rx_byte,
  output logic done,
  output logic busy
);
  import spims_pkg::*;

  localparam logic [15:0] HALF_M1 = 16'(HALF_CYCLES - 1);

  spims_peer_state_t state_reg;
  logic [15:0] tim_reg;
  logic act_reg, ss_reg, out_bit_reg, sclk_prev_reg;
  logic [7:0] shreg, rx_reg;
  logic [3:0] cnt_reg;
  logic done_reg;
  logic tim_last, lead, trail, sample, launch, last_trail, load;
  logic s_sel, s_lead, s_trail;
  logic [7:0] sh_next;

  assign tim_last = tim_reg == HALF_M1;
  assign s_sel = ~act_master & ~sel_n;
  assign s_lead = s_sel & (sclk_prev_reg == clock_idle_level_bit) & (link.sclk != clock_idle_level_bit);
  assign s_trail = s_sel & (sclk_prev_reg != clock_idle_level_bit) & (link.sclk == clock_idle_level_bit);
  assign lead = act_master ?
                (state_reg == PS_RUN) & tim_last & ~act_reg : s_lead;
  assign trail = act_master ?
                 (state_reg == PS_RUN) & tim_last & act_reg : s_trail;
  assign sample = clock_edge_select_bit ? trail : lead;   // see R4
  assign launch = clock_edge_select_bit ? lead : trail;
  assign sh_next = {shreg[6:0], act_master ? link.miso : link.mosi};
  assign last_trail = trail &
      (cnt_reg == (clock_edge_select_bit ? BYTE_BITS - 4'h1 : BYTE_BITS)); // see R1
  assign busy = act_master ? (state_reg != PS_IDLE) : (cnt_reg != 4'h0);
  assign load = start & ~busy;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PS_IDLE;
    end else begin
      case (state_reg)
        PS_IDLE: if (load && act_master) state_reg <= PS_SETUP;
        PS_SETUP: if (tim_last) state_reg <= PS_RUN;
        PS_RUN: if (last_trail) state_reg <= PS_HOLD;
        PS_HOLD: if (tim_last) state_reg <= PS_IDLE;
        default: state_reg <= PS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tim_reg <= 16'h0000;
    end else if (state_reg == PS_IDLE || tim_last) begin
      tim_reg <= 16'h0000;
    end else begin
      tim_reg <= tim_reg + 16'h0001;
    end
  end

  // Select framed around each byte keeps phase-0 slaves happy
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ss_reg <= 1'b1;
    end else if (load && act_master) begin
      ss_reg <= 1'b0; // see R11
    end else if (state_reg == PS_HOLD && tim_last) begin
      ss_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_reg <= 1'b0;
    end else if (state_reg != PS_RUN) begin
      act_reg <= 1'b0;
    end else if (tim_last) begin
      act_reg <= ~act_reg;
    end
  end

  // ---------------------------------------------------------------
  // Shifter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_reg <= 1'b0;
      shreg <= DATA_RESET;
      out_bit_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else begin
      sclk_prev_reg <= link.sclk;
      if (load) begin
        shreg <= tx_byte;
        out_bit_reg <= tx_byte[7]; // see R6
        cnt_reg <= 4'h0;
      end else begin
        if (sample) shreg <= sh_next;
        if (launch) out_bit_reg <= shreg[7];
        if (act_master ? last_trail : (sample && cnt_reg ==
            BYTE_BITS - 4'h1)) begin
          cnt_reg <= 4'h0;
        end else if (sample) begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_reg <= DATA_RESET;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (act_master ? last_trail :
          (sample && cnt_reg == BYTE_BITS - 4'h1)) begin
        rx_reg <= (sample) ? sh_next : shreg;
        done_reg <= 1'b1;
      end
    end
  end

  assign rx_byte = rx_reg;
  assign done = done_reg;
  assign link.peer_sclk_o = clock_idle_level_bit ^ act_reg;
  assign link.peer_sclk_oe = act_master;
  assign link.peer_mosi_o = out_bit_reg;
  assign link.peer_mosi_oe = act_master;
  // Slave answers straight from the shifter: a launch register would lag
  // the one-cycle edge detect behind a divide-by-two clock
  assign link.peer_miso_o = shreg[7];
  assign link.peer_miso_oe = s_sel;
  assign link.peer_ss_n_o = ss_reg;
  assign link.peer_ss_n_oe = act_master;
endmodule // spims_peer

// [core/spims_port.sv]
// Byte-wide full-duplex serial port, master or slave, with APB registers.
// Assumes link pins are synchronous to sys_clk; port pins fall back to
// general-purpose use while the port is disabled.
`timescale 1ns/1ps
// Notes on behaviour
// R1: one bit each way per clock period
// R2: clock pin drives as master, input as slave
// R3: slave polarity and phase match the master
// R4: launch on one edge, sample the other
// R5: slave-out line input as master, driven as slave
// R6: eight-bit bytes, most significant bit first
// R7: master-out line driven as master, input as slave
// R8: select used only in slave mode, low active
// R9: slave shifts only while select low
// R10: phase one lets select stay low across bytes
// R11: phase zero needs select framed per byte
// R12: slave mode reads select level at rate bit
// R13: done flag set per byte, cleared by write/read
// R14: collision flag on busy data write, software clears
// R15: enable bit hands pins to the port
// R16: mode bit picks master or slave
// R17: polarity bit sets clock idle level
// R18: phase bit picks launching edge
// R19: rate field divides core clock 2/4/8/16
// R20: event shares one vector with two-wire port
// R21: master data write starts eight clocks
// R22: slave byte ends at eighth clock or select rise
// R23: select pin unused in master mode
// R24: colliding write leaves current byte untouched
module spims_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [spims_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic spi_event,
  spims_link_if.dev link
);
  import spims_pkg::*;

  spims_state_t state_reg;
  logic [5:0] cfg_reg;
  logic done_reg, write_collision_flag_reg;
  logic [7:0] data_reg, shreg, gpio_reg;
  logic [31:0] prdata_reg;
  logic [3:0] cnt_reg, div_reg;
  logic act_reg, out_bit_reg, sclk_prev_reg, ss_prev_reg;

  logic en, mst, clock_idle_level_bit, clock_edge_select_bit;
  logic [1:0] rate;
  logic [3:0] half_m1;
  logic setup, access, hit_ctrl, hit_data, hit_gpio;
  logic wr_ctrl, wr_data, wr_gpio, rd_data, busy, load, start;
  logic tick, s_sel, s_lead, s_trail, lead, trail, sample, launch;
  logic last_trail, ss_rise, finish, abort;
  logic [7:0] sh_next, ctrl_view;

  assign en = cfg_reg[BIT_EN];
  assign mst = cfg_reg[BIT_MST];
  assign clock_idle_level_bit = cfg_reg[BIT_CLOCK_IDLE_LEVEL_BIT];
  assign clock_edge_select_bit = cfg_reg[BIT_CLOCK_EDGE_SELECT_BIT];
  assign rate = cfg_reg[BIT_RATE_HI:BIT_RATE_LO];

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit_ctrl = paddr == CTRL_ADDR;
  assign hit_data = paddr == DATA_ADDR;
  assign hit_gpio = paddr == GPIO_ADDR;
  assign wr_ctrl = access & pwrite & hit_ctrl;
  assign wr_data = access & pwrite & hit_data;
  assign wr_gpio = access & pwrite & hit_gpio;
  assign rd_data = access & ~pwrite & hit_data;
  assign pready = 1'b1;
  assign pslverr = access & ~(hit_ctrl | hit_data | hit_gpio);
  assign prdata = prdata_reg;

  // Select level replaces the low rate bit on reads in slave mode
  assign ctrl_view = {done_reg, write_collision_flag_reg, cfg_reg[5:1],
                      mst ? cfg_reg[BIT_RATE_LO] : link.ss_n}; // see R12

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h00000000;
    end else if (setup) begin
      if (hit_ctrl) prdata_reg <= {24'h000000, ctrl_view};
      else if (hit_data) prdata_reg <= {24'h000000, data_reg};
      else if (hit_gpio) prdata_reg <= {20'h00000, link.ss_n, link.miso,
                                       link.mosi, link.sclk, gpio_reg};
      else prdata_reg <= 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= CTRL_RESET[5:0];
      gpio_reg <= GPIO_RESET;
    end else begin
      if (wr_ctrl) cfg_reg <= pwdata[5:0]; // see R15, R16, R17, R18
      if (wr_gpio) gpio_reg <= pwdata[7:0];
    end
  end

  // Hardware set beats a same-cycle clear; software can only clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= CTRL_RESET[BIT_DONE];
      write_collision_flag_reg <= CTRL_RESET[BIT_WRITE_COLLISION_FLAG];
    end else begin
      done_reg <= finish | (done_reg & ~rd_data &
                  ~(wr_ctrl & ~pwdata[BIT_DONE])); // see R13
      write_collision_flag_reg <= (wr_data & busy) | (write_collision_flag_reg &
                  ~(wr_ctrl & ~pwdata[BIT_WRITE_COLLISION_FLAG])); // see R14
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= DATA_RESET;
    end else if (finish) begin
      data_reg <= (sample) ? sh_next : shreg; // see R21
    end
  end

  assign spi_event = done_reg; // see R20

  // ---------------------------------------------------------------
  // Engine
  // ---------------------------------------------------------------
  assign busy = state_reg != ST_IDLE;
  assign load = wr_data & ~busy; // see R24
  assign start = load & en & mst; // see R21
  assign half_m1 = (4'h1 << rate) - 4'h1; // see R19
  assign tick = (state_reg == ST_RUN) & mst & (div_reg == half_m1);
  // Select is looked at only in slave mode
  assign s_sel = en & ~mst & ~link.ss_n; // see R8, R9, R23
  assign s_lead = s_sel & (sclk_prev_reg == clock_idle_level_bit) & (link.sclk != clock_idle_level_bit);
  assign s_trail = s_sel & (sclk_prev_reg != clock_idle_level_bit) & (link.sclk == clock_idle_level_bit);
  assign lead = mst ? tick & ~act_reg : s_lead; // see R3
  assign trail = mst ? tick & act_reg : s_trail;
  assign sample = clock_edge_select_bit ? trail : lead; // see R4, R18
  assign launch = clock_edge_select_bit ? lead : trail;
  assign sh_next = {shreg[6:0], mst ? link.miso : link.mosi}; // see R6
  assign last_trail = trail &
      (cnt_reg == (clock_edge_select_bit ? BYTE_BITS - 4'h1 : BYTE_BITS)); // see R1
  assign ss_rise = ~ss_prev_reg & link.ss_n;
  // Phase one ends on the eighth clock, so select may stay low
  assign finish = (state_reg == ST_RUN) & ((mst | clock_edge_select_bit) ? last_trail :
                  ss_rise & (cnt_reg == BYTE_BITS)); // see R22, R10, R11
  // A select rise mid-byte drops the partial byte
  assign abort = (state_reg == ST_RUN) & ~mst & link.ss_n & ~finish;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: if (start || s_lead) state_reg <= ST_RUN;
        ST_RUN: if (finish || abort) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 4'h0;
    end else if (state_reg != ST_RUN || tick) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_reg <= 1'b0;
    end else if (state_reg != ST_RUN || !mst) begin
      act_reg <= 1'b0;
    end else if (tick) begin
      act_reg <= ~act_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= DATA_RESET;
      out_bit_reg <= 1'b0;
      cnt_reg <= 4'h0;
      sclk_prev_reg <= 1'b0;
      ss_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= link.sclk;
      ss_prev_reg <= link.ss_n;
      if (load) begin
        shreg <= pwdata[7:0];
        out_bit_reg <= pwdata[7]; // see R6
        cnt_reg <= 4'h0;
      end else begin
        if (sample) shreg <= sh_next;
        if (launch) out_bit_reg <= shreg[7];
        if (finish || abort) cnt_reg <= 4'h0;
        else if (sample) cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  assign link.dev_sclk_o = en ? clock_idle_level_bit ^ act_reg : gpio_reg[0]; // see R17
  assign link.dev_sclk_oe = en ? mst : gpio_reg[GPIO_PINS]; // see R2
  assign link.dev_mosi_o = en ? out_bit_reg : gpio_reg[1];
  assign link.dev_mosi_oe = en ? mst : gpio_reg[GPIO_PINS+1]; // see R7
  assign link.dev_miso_o = en ? out_bit_reg : gpio_reg[2];
  // Slave drives only while selected so several slaves can share
  assign link.dev_miso_oe = en ? s_sel : gpio_reg[GPIO_PINS+2]; // see R5
  assign link.dev_ss_n_o = gpio_reg[3];
  assign link.dev_ss_n_oe = en ? 1'b0 : gpio_reg[GPIO_PINS+3];
endmodule // spims_port

// [dv/spims_asserts.sv]
// Concurrent checks on the serial link between port and partner.
// Assumes link signals sampled on sys_clk, partner at four core cycles
// per half serial clock.
`timescale 1ns/1ps
module spims_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic dev_sclk_oe,
  input wire logic dev_mosi_oe,
  input wire logic dev_miso_oe,
  input wire logic dev_ss_n_oe,
  input wire logic peer_sclk_oe,
  input wire logic sclk,
  input wire logic ss_n
);
  logic sclk_q;
  logic oe_q;
  logic [3:0] dev_cnt;
  logic [4:0] quiet;
  logic [4:0] peer_cnt;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // Edge bookkeeping
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      oe_q <= dev_sclk_oe;
    end
  end

  // Wraps at sixteen, so back-to-back bursts need no gap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) dev_cnt <= 4'h0;
    else if (dev_sclk_oe && oe_q && sclk != sclk_q) dev_cnt <= dev_cnt + 4'h1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) quiet <= 5'h00;
    else if (sclk != sclk_q) quiet <= 5'h00;
    else if (quiet != 5'h1F) quiet <= quiet + 5'h01;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) peer_cnt <= 5'h00;
    else if (ss_n) peer_cnt <= 5'h00;
    else if (peer_sclk_oe && sclk != sclk_q) peer_cnt <= peer_cnt + 5'h01;
  end

  // ---------------------------------------------------------------
  // Pin directions and framing
  // ---------------------------------------------------------------
  a_master_pins: assert property (
    dev_sclk_oe |-> dev_mosi_oe && !dev_miso_oe)
    else $error("master pin directions wrong");
  a_master_no_select: assert property (
    dev_sclk_oe |-> !dev_ss_n_oe)
    else $error("master drives select pin");
  a_slave_out_select: assert property (
    dev_miso_oe |-> !ss_n || !$past(ss_n))
    else $error("slave output driven while deselected");
  a_slave_in_pins: assert property (
    peer_sclk_oe && !ss_n |-> !dev_sclk_oe && !dev_mosi_oe)
    else $error("slave drives clock or master-out line");
  a_slave_drives: assert property (
    peer_sclk_oe && !ss_n && !$past(ss_n) && !$past(ss_n, 2) |->
    dev_miso_oe)
    else $error("selected slave leaves output undriven");
  a_burst_count: assert property (
    dev_sclk_oe && quiet == 5'd17 |-> dev_cnt == 4'h0)
    else $error("master burst not sixteen clock edges");
  a_peer_frame_edges: assert property (
    peer_sclk_oe && $rose(ss_n) |-> peer_cnt == 5'd16)
    else $error("partner frame not sixteen clock edges");
  a_peer_setup: assert property (
    peer_sclk_oe && $fell(ss_n) |-> $stable(sclk) [*3])
    else $error("clock moved too soon after select");
  a_peer_clock_framed: assert property (
    peer_sclk_oe && $past(peer_sclk_oe) && ss_n && $past(ss_n) |->
    $stable(sclk))
    else $error("clock moved outside a frame");
endmodule // spims_asserts

// [dv/test_spi_master_slave_port.sv]
// Self-checking bench: port and partner joined by the link interface.
// Assumes a 125 MHz core clock and zero-wait-state register access.
`timescale 1ns/1ps
module test_spi_master_slave_port;
  import spims_pkg::*;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, spi_event;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic err_q;
  logic p_master, p_clock_idle_level_bit, p_clock_edge_select_bit, p_sel_n, p_start, p_done, p_busy;
  logic [7:0] p_tx, p_rx;
  int n_mismatch = 0;
  int check_count = 0;

  spims_link_if link ();
  spims_port u_spims_port (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .spi_event(spi_event), .link(link));
  spims_peer #(.HALF_CYCLES(4)) u_spims_peer (.sys_clk(sys_clk),
    .rst_n(rst_n), .link(link), .act_master(p_master), .clock_idle_level_bit(p_clock_idle_level_bit),
    .clock_edge_select_bit(p_clock_edge_select_bit), .sel_n(p_sel_n), .tx_byte(p_tx), .start(p_start),
    .rx_byte(p_rx), .done(p_done), .busy(p_busy));
  spims_asserts u_spims_asserts (.sys_clk(sys_clk), .rst_n(rst_n),
    .dev_sclk_oe(link.dev_sclk_oe), .dev_mosi_oe(link.dev_mosi_oe),
    .dev_miso_oe(link.dev_miso_oe), .dev_ss_n_oe(link.dev_ss_n_oe),
    .peer_sclk_oe(link.peer_sclk_oe), .sclk(link.sclk), .ss_n(link.ss_n));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Entered just after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w,
      input logic [7:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    apb(CTRL_ADDR, 1'b0, 8'h00);
    check("ctrl reset", rd_q, {24'h0, CTRL_RESET});
    apb(DATA_ADDR, 1'b0, 8'h00);
    check("data reset", rd_q, {24'h0, DATA_RESET});
    apb(12'h004, 1'b1, 8'h5A);
    check("unmapped err", {31'h0, err_q}, 32'h1);
    apb(12'h004, 1'b0, 8'h00);
    check("unmapped rd", {err_q, rd_q[30:0]}, 32'h80000000);
  endtask

  task automatic t_gpio;
    apb(CTRL_ADDR, 1'b1, 8'h00);
    apb(GPIO_ADDR, 1'b1, 8'h20);
    check("gpio pins", {28'h0, link.dev_sclk_oe, link.dev_mosi_oe,
      link.mosi, link.dev_miso_oe}, 32'h4);
    apb(GPIO_ADDR, 1'b0, 8'h00);
    check("gpio read", {23'h0, rd_q[9], rd_q[7:0]}, 32'h20);
    apb(GPIO_ADDR, 1'b1, 8'h00);
  endtask

  task automatic t_master(input logic [1:0] rate, input logic pol,
      input logic pha, input logic [7:0] tx, input logic [7:0] ptx,
      input logic collide);
    logic [7:0] cfg;
    int n;
    cfg = {4'h3, pol, pha, rate};
    p_clock_idle_level_bit <= pol;
    p_clock_edge_select_bit <= pha;
    p_tx <= ptx;
    apb(CTRL_ADDR, 1'b1, 8'h00);
    apb(CTRL_ADDR, 1'b1, cfg);
    check("idle level", {31'h0, link.sclk}, {31'h0, pol});
    // Partner selected and loaded only once the idle level stands
    p_sel_n <= 1'b0;
    p_start <= 1'b1;
    @(posedge sys_clk);
    p_start <= 1'b0;
    apb(DATA_ADDR, 1'b1, tx);
    n = 1;
    if (collide) begin
      apb(DATA_ADDR, 1'b1, ~tx);
      n = 4;
    end
    while (spi_event !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    // Flag shows one edge after the sixteenth half period
    check("burst time", 32'(n - (16 << rate)), 32'h1);
    apb(CTRL_ADDR, 1'b0, 8'h00);
    check("flags set", rd_q, {24'h0, 1'b1, collide, cfg[5:0]});
    p_sel_n <= 1'b1;
    apb(DATA_ADDR, 1'b0, 8'h00);
    check("master rx", rd_q, {24'h0, ptx});
    check("peer rx", {24'h0, p_rx}, {24'h0, tx});
    apb(CTRL_ADDR, 1'b0, 8'h00);
    check("done cleared", rd_q, {25'h0, collide, cfg[5:0]});
    check("event low", {31'h0, spi_event}, 32'h0);
    if (collide) begin
      apb(CTRL_ADDR, 1'b1, cfg);
      apb(CTRL_ADDR, 1'b0, 8'h00);
      check("write_collision_flag cleared", rd_q, {24'h0, cfg});
    end
  endtask

  task automatic t_slave(input logic pol, input logic pha,
      input logic [7:0] tx, input logic [7:0] ptx);
    logic [7:0] cfg;
    int n;
    cfg = {4'h2, pol, pha, 2'b10};
    p_clock_idle_level_bit <= pol;
    p_clock_edge_select_bit <= pha;
    p_tx <= ptx;
    apb(CTRL_ADDR, 1'b1, 8'h00);
    apb(CTRL_ADDR, 1'b1, cfg);
    // Clock may jump here while deselected; the port must ignore it
    p_master <= 1'b1;
    apb(DATA_ADDR, 1'b1, tx);
    apb(CTRL_ADDR, 1'b0, 8'h00);
    check("select high", rd_q, {24'h0, cfg[7:1], 1'b1});
    p_start <= 1'b1;
    @(posedge sys_clk);
    p_start <= 1'b0;
    repeat (8) @(posedge sys_clk);
    apb(CTRL_ADDR, 1'b0, 8'h00);
    check("select low", rd_q, {24'h0, cfg[7:1], 1'b0});
    n = 0;
    while (p_done !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    if (!pha) check("no early flag", {31'h0, spi_event}, 32'h0);
    while (spi_event !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    check("slave done", {31'h0, n < 300}, 32'h1);
    apb(DATA_ADDR, 1'b0, 8'h00);
    check("slave rx", rd_q, {24'h0, ptx});
    check("peer rx", {24'h0, p_rx}, {24'h0, tx});
    p_master <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Clock, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    p_master = 1'b0;
    p_clock_idle_level_bit = 1'b0;
    p_clock_edge_select_bit = 1'b0;
    p_sel_n = 1'b1;
    p_start = 1'b0;
    p_tx = 8'h00;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs;
    t_gpio;
    for (int i = 0; i < 4; i++) begin
      t_master(i[1:0], i[1], i[0], 8'h96 ^ 8'(i), 8'h3C ^ 8'(i << 4), i == 2);
    end
    t_slave(1'b0, 1'b0, 8'hC3, 8'h5A);
    t_slave(1'b1, 1'b1, 8'h81, 8'h7E);
    end_of_test;
  end

  // Whole run is under a thousand cycles; this only cuts a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test;
  end
endmodule // test_spi_master_slave_port
